// >>> hw/bdsp_pkg.sv
package bdsp_pkg;
  localparam int WORD_W = 17;
  localparam int DATA_W = 16;
  localparam int STAT_BIT = 16;
  localparam logic [4:0] BIT_COUNT = 5'h11;
  localparam logic [15:0] RESP_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] RESP_NOT_READY = 16'h0000;
  localparam logic [15:0] RESP_BUS_ERR = 16'h0001;
  localparam logic [15:0] SRC_OPCODE_HI = 16'h0000;
  localparam logic [15:0] SRC_OPCODE_LO = 16'h0001;
  localparam logic [31:0] SRC_BREAKPOINT = 32'h00000000;
  localparam logic [31:0] PTR_RESET_FAULT = 32'h00000001;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int RW_BIT = 8;
  localparam int SZ_MSB = 7;
  localparam int SZ_LSB = 6;
  localparam int AD_BIT = 3;
  localparam int REG_MSB = 2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [5:0] OPC_RESUME = 6'h03;
  localparam logic [5:0] OPC_CALL = 6'h02;
  localparam logic [5:0] OPC_READ_REG = 6'h08;
  localparam logic [5:0] OPC_WRITE_REG = 6'h09;
  localparam logic [5:0] OPC_NOP = 6'h00;
  localparam logic [2:0] SREG_RETURN = 3'h0;
  localparam logic [2:0] SREG_CURRENT = 3'h1;
  localparam logic [2:0] SREG_SCRATCH = 3'h2;
  localparam logic [2:0] SREG_FAULT = 3'h3;
  typedef enum logic [1:0] {
    BDSP_ENTRY_BREAKPOINT_REQUEST_N = 2'h0,
    BDSP_ENTRY_OPCODE = 2'h1,
    BDSP_ENTRY_DBLFLT = 2'h2
  } bdsp_entry_t;
endpackage

// >>> hw/bdsp_word_if.sv
interface bdsp_word_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// >>> hw/bdsp_buf2.sv
module bdsp_buf2 (
  input wire logic i_core_clk,
  input wire logic i_srst,
  bdsp_word_if.dst in_w,
  bdsp_word_if.src out_w
);
  logic [15:0] mem_r [2];
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  logic push, pop;
  assign in_w.ready = (cnt_r != 2'h2);
  assign out_w.valid = (cnt_r != 2'h0);
  assign out_w.data = mem_r[rp_r];
  assign push = in_w.valid && in_w.ready;
  assign pop = out_w.valid && out_w.ready;
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_w.data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // bdsp_buf2

// >>> hw/bdsp_port.sv
module bdsp_port (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Shared pins.
  input wire logic i_breakpoint_request_n,
  input wire logic i_fetch_track_pin,
  output logic o_pipe_track_pin,
  output logic o_halted,
  // Core pipeline tracking when not halted.
  input wire logic i_pipe_track_core,
  // Entry events from the core.
  input wire logic i_entry_opcode,
  input wire logic i_double_fault,
  input wire logic i_fault_from_reset,
  input wire logic [15:0] i_special_status_word,
  input wire logic [31:0] i_last_instr_addr,
  // Bus cycle tracking.
  input wire logic i_bus_cycle,
  input wire logic [31:0] i_bus_addr,
  input wire logic i_bus_fault,
  // Command words to the core and their results.
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_data,
  input wire logic i_cmd_ready,
  input wire logic i_res_valid,
  input wire logic [15:0] i_res_data,
  input wire logic i_res_bus_error,
  input wire logic i_res_illegal,
  input wire logic i_supervisor_bit,
  // Exit towards the fetch unit.
  output logic o_flush,
  output logic [31:0] o_fetch_addr,
  output logic o_fetch_supervisor,
  output logic o_odd_fetch_error,
  output logic o_debug_enabled,
  output logic [31:0] o_return_pointer
);
  logic clk_s1_r, clk_s2_r, clk_d_r, din_s1_r, din_s2_r, bk_s1_r, bk_s2_r;
  logic enabled_r, halted_r, was_rst_r, rise, rise_d_r, adv_r;
  logic [4:0] cnt_r;
  logic [16:0] rx_r, tx_r;
  logic [31:0] scratch_r, fault_r, ret_r, cur_r;
  logic [1:0] ext_need_r;
  logic [5:0] cur_op_r;
  logic [2:0] cur_reg_r;
  logic ext_hi_r, exit_r;
  bdsp_word_if rxw ();
  bdsp_word_if cmdw ();

  function automatic logic [1:0] ext_words(input logic [15:0] w);
    logic [5:0] op;
    op = w[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB];
    if (op == bdsp_pkg::OPC_WRITE_REG) begin
      ext_words = 2'h2;
    end else begin
      ext_words = 2'h0;
    end
  endfunction

  // Pin inputs pass two flops; clock pin doubles as breakpoint request.
  always_ff @(posedge i_core_clk) begin
    clk_s1_r <= i_breakpoint_request_n;
    clk_s2_r <= clk_s1_r;
    din_s1_r <= i_fetch_track_pin;
    din_s2_r <= din_s1_r;
    clk_d_r <= clk_s2_r;
  end
  assign bk_s2_r = clk_s2_r;
  assign bk_s1_r = clk_s1_r;

  // Strap caught on the first clock after reset release.
  always_ff @(posedge i_core_clk) begin
    was_rst_r <= i_srst;
    if (was_rst_r && !i_srst) begin
      enabled_r <= ~clk_s2_r;
    end else if (i_srst) begin
      enabled_r <= 1'b0;
    end
  end
  assign o_debug_enabled = enabled_r;

  // The pin may still be held low as a breakpoint request when halt begins.
  // Its release must not count as a first serial edge, so the serial side
  // only arms once it has seen the clock high for two samples.
  logic serial_on_r;
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !halted_r) begin
      serial_on_r <= 1'b0;
    end else if (clk_s2_r && clk_d_r) begin
      serial_on_r <= 1'b1;
    end
  end

  // Rising edge only counts while halted; idle high clock gives none.
  assign rise = halted_r && serial_on_r && clk_s2_r && !clk_d_r;

  // Halt control.
  logic breakpoint_request_n_hit;
  assign breakpoint_request_n_hit = enabled_r && !clk_s2_r && !halted_r && !was_rst_r;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      halted_r <= 1'b0;
    end else if (exit_r) begin
      halted_r <= 1'b0;
    end else if (enabled_r && (breakpoint_request_n_hit || i_entry_opcode || i_double_fault)) begin
      halted_r <= 1'b1;
    end
  end
  assign o_halted = halted_r;

  // Entry source signature and current instruction pointer.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      scratch_r <= 32'h00000000;
      cur_r <= 32'h00000000;
    end else if (!halted_r && enabled_r) begin
      if (i_double_fault) begin
        scratch_r <= {i_special_status_word, bdsp_pkg::RESP_ALL_ONES};
        cur_r <= i_fault_from_reset ? bdsp_pkg::PTR_RESET_FAULT : i_last_instr_addr;
      end else if (i_entry_opcode) begin
        scratch_r <= {bdsp_pkg::SRC_OPCODE_HI, bdsp_pkg::SRC_OPCODE_LO};
        cur_r <= i_last_instr_addr;
      end else if (breakpoint_request_n_hit) begin
        scratch_r <= bdsp_pkg::SRC_BREAKPOINT;
        cur_r <= i_last_instr_addr;
      end
    end
  end

  // Fault address follows bus cycles, so a fault leaves its own address.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      fault_r <= 32'h00000000;
    end else if (i_bus_cycle || i_bus_fault) begin
      fault_r <= i_bus_addr;
    end
  end

  // Receive side: shift, count, latch one clock after the edge.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !halted_r) begin
      cnt_r <= bdsp_pkg::BIT_COUNT;
      rx_r <= 17'h00000;
      rise_d_r <= 1'b0;
    end else begin
      rise_d_r <= rise;
      if (rise) begin
        rx_r <= {rx_r[15:0], din_s2_r};
        cnt_r <= cnt_r - 5'h01;
      end else if (rise_d_r && cnt_r == 5'h00) begin
        cnt_r <= bdsp_pkg::BIT_COUNT;
      end
    end
  end
  logic word_done;
  assign word_done = rise_d_r && (cnt_r == 5'h00);
  assign rxw.valid = word_done;
  assign rxw.data = rx_r[15:0];

  // Buffer between the serial word latch and the core's command port.
  bdsp_buf2 u_buf (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst || !halted_r),
    .in_w(rxw),
    .out_w(cmdw)
  );
  assign o_cmd_valid = cmdw.valid;
  assign o_cmd_data = cmdw.data;

  // Command assembly: track opcode and remaining extension words.
  logic take;
  assign take = cmdw.valid && cmdw.ready;
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !halted_r) begin
      ext_need_r <= 2'h0;
      cur_op_r <= bdsp_pkg::OPC_NOP;
      cur_reg_r <= 3'h0;
      ext_hi_r <= 1'b0;
    end else if (take) begin
      if (ext_need_r == 2'h0) begin
        cur_op_r <= cmdw.data[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB];
        cur_reg_r <= cmdw.data[bdsp_pkg::REG_MSB:0];
        ext_need_r <= ext_words(cmdw.data);
        ext_hi_r <= 1'b1;
      end else begin
        ext_need_r <= ext_need_r - 2'h1;
        ext_hi_r <= 1'b0;
      end
    end
  end
  assign cmdw.ready = i_cmd_ready;

  // Return pointer: written by the write-register command, most significant word first.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ret_r <= 32'h00000000;
    end else if (take && ext_need_r != 2'h0 && cur_op_r == bdsp_pkg::OPC_WRITE_REG
                 && cur_reg_r == bdsp_pkg::SREG_RETURN) begin
      if (ext_hi_r) begin
        ret_r[31:16] <= cmdw.data;
      end else begin
        ret_r[15:0] <= cmdw.data;
      end
    end else if (!halted_r && enabled_r && (i_entry_opcode || i_double_fault)) begin
      ret_r <= i_last_instr_addr;
    end
  end
  assign o_return_pointer = ret_r;

  // Exit on resume or call only, once the command word is taken.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      exit_r <= 1'b0;
    end else begin
      exit_r <= take && ext_need_r == 2'h0 && halted_r
        && (cmdw.data[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB] == bdsp_pkg::OPC_RESUME
        || cmdw.data[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB] == bdsp_pkg::OPC_CALL);
    end
  end

  // Flush and first prefetch are issued in the same cycle that halted drops.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_flush <= 1'b0;
      o_fetch_addr <= 32'h00000000;
      o_fetch_supervisor <= 1'b0;
      o_odd_fetch_error <= 1'b0;
    end else begin
      o_flush <= exit_r;
      o_fetch_addr <= ret_r;
      o_fetch_supervisor <= i_supervisor_bit;
      o_odd_fetch_error <= exit_r && ret_r[0];
    end
  end

  // Read of a context register: high word at once, low word after the next word.
  logic [31:0] rd_word;
  logic rd_take, rd_lo_pend_r, rd_lo_go_r;
  logic [15:0] rd_lo_r;
  always_comb begin
    case (cmdw.data[bdsp_pkg::REG_MSB:0])
      bdsp_pkg::SREG_RETURN: rd_word = ret_r;
      bdsp_pkg::SREG_CURRENT: rd_word = cur_r;
      bdsp_pkg::SREG_SCRATCH: rd_word = scratch_r;
      bdsp_pkg::SREG_FAULT: rd_word = fault_r;
      default: rd_word = 32'h00000000;
    endcase
  end
  assign rd_take = take && ext_need_r == 2'h0
    && cmdw.data[bdsp_pkg::OP_MSB:bdsp_pkg::OP_LSB] == bdsp_pkg::OPC_READ_REG;
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !halted_r) begin
      rd_lo_r <= 16'h0000;
      rd_lo_pend_r <= 1'b0;
      rd_lo_go_r <= 1'b0;
    end else begin
      rd_lo_go_r <= word_done && rd_lo_pend_r;
      if (rd_take) begin
        rd_lo_r <= rd_word[15:0];
        rd_lo_pend_r <= 1'b1;
      end else if (rd_lo_go_r) begin
        rd_lo_pend_r <= 1'b0;
      end
    end
  end

  // Transmit register: shifts one core clock after the rising edge.
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !halted_r) begin
      tx_r <= {1'b1, bdsp_pkg::RESP_NOT_READY};
      adv_r <= 1'b0;
    end else begin
      adv_r <= rise;
      if (word_done) begin
        tx_r <= {1'b1, bdsp_pkg::RESP_NOT_READY};
      end else if (rd_lo_go_r) begin
        tx_r <= {1'b0, rd_lo_r};
      end else if (rd_take) begin
        tx_r <= {1'b0, rd_word[31:16]};
      end else if (i_res_valid || i_res_bus_error || i_res_illegal) begin
        if (i_res_illegal) begin
          tx_r <= {1'b1, bdsp_pkg::RESP_ALL_ONES};
        end else if (i_res_bus_error) begin
          tx_r <= {1'b1, bdsp_pkg::RESP_BUS_ERR};
        end else begin
          tx_r <= {1'b0, i_res_data};
        end
      end else if (adv_r) begin
        tx_r <= {tx_r[15:0], 1'b0};
      end
    end
  end

  // Pipe pin carries serial out only while halted.
  assign o_pipe_track_pin = halted_r ? tx_r[bdsp_pkg::STAT_BIT] : i_pipe_track_core;

  // Read-back of context registers bypasses the core's result path; tx_r loads from rd_word.
  logic unused_ok;
  assign unused_ok = ^{bk_s1_r, bk_s2_r};

  count_ok_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    rise && halted_r && !word_done |=> cnt_r == $past(cnt_r) - 5'h01)
    else $error("bit counter did not step");
  nr_load_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    word_done && halted_r |=> tx_r == {1'b1, bdsp_pkg::RESP_NOT_READY})
    else $error("not ready not loaded");
  bus_err_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    halted_r && !word_done && i_res_bus_error && !i_res_illegal ##1 halted_r
    |-> tx_r == {1'b1, bdsp_pkg::RESP_BUS_ERR})
    else $error("bus error response wrong");
  halt_out_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    exit_r |=> !o_halted && o_flush)
    else $error("halted not dropped on exit");
  odd_err_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    exit_r && ret_r[0] |=> o_odd_fetch_error)
    else $error("odd return pointer not flagged");
  dso_mux_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    halted_r |-> o_pipe_track_pin == tx_r[16])
    else $error("serial out not on pipe pin");
  entry_sig_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !halted_r && enabled_r && i_entry_opcode && !i_double_fault
    |=> scratch_r == 32'h00000001)
    else $error("opcode signature wrong");
  fault_addr_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_bus_fault |=> fault_r == $past(i_bus_addr))
    else $error("fault address not kept");
  reset_ptr_a: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !halted_r && enabled_r && i_double_fault && i_fault_from_reset
    |=> cur_r == bdsp_pkg::PTR_RESET_FAULT)
    else $error("reset fault pointer wrong");
endmodule // bdsp_port

// >>> test/bdsp_host_model.sv
module bdsp_host_model (
  // Serial link towards the port.
  output logic o_clk,
  output logic o_data,
  input wire logic i_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Period of 800 ns stays well below half the core clock rate.
  localparam int HALF_NS = 400;

  initial begin
    o_clk = 1'b1;
    o_data = 1'b0;
  end

  // The clock idles high and dips low once per bit, so no stray edge reaches the port.
  task automatic xfer(input logic [16:0] w, output logic [16:0] r);
    #23;
    for (int i = 16; i >= 0; i--) begin
      o_clk = 1'b0;
      o_data = w[i];
      #HALF_NS;
      o_clk = 1'b1;
      r[i] = i_data;
      #HALF_NS;
    end
    // Released data line flips so a stale level never passes for a driven one.
    o_data = ~o_data;
  endtask
endmodule // bdsp_host_model

// >>> test/tb_bdsp_port.sv
`define CHECK_EQ(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_bdsp_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic breakpoint_request_n_n = 1'b0;
  logic host_clk, host_dout, pipe_pin, halted, flush, fetch_sup, odd_err, dbg_en, cmd_valid;
  logic pipe_core = 1'b0, entry_op = 1'b0, dbl = 1'b0, from_rst = 1'b0, sup = 1'b1;
  logic bus_cyc = 1'b0, bus_flt = 1'b0, cmd_ready = 1'b1, stall = 1'b0;
  logic res_valid = 1'b0, res_bus_error_termination = 1'b0, res_ill = 1'b0, odd_seen = 1'b0;
  logic f_halt, f_sup;
  logic [15:0] special_status_word = 16'h0000, res_data = 16'h0000, cmd_data, rnd16;
  logic [31:0] last_addr = 32'h00000000, bus_addr = 32'h00000000, fetch_addr, ret_ptr, rp, f_addr;
  logic [17:0] exp_tx = 18'h20000;
  logic [17:0] exp_q[$];
  logic [15:0] cq[$];
  int err_count = 0, checks = 0, cycles = 0, n_flush = 0;
  int seed = 32'h36223421;

  bdsp_port u_bdsp_port (
    .i_core_clk(clk), .i_srst(srst),
    .i_breakpoint_request_n(breakpoint_request_n_n & host_clk), .i_fetch_track_pin(host_dout),
    .o_pipe_track_pin(pipe_pin), .o_halted(halted), .i_pipe_track_core(pipe_core),
    .i_entry_opcode(entry_op), .i_double_fault(dbl), .i_fault_from_reset(from_rst),
    .i_special_status_word(special_status_word), .i_last_instr_addr(last_addr),
    .i_bus_cycle(bus_cyc), .i_bus_addr(bus_addr), .i_bus_fault(bus_flt),
    .o_cmd_valid(cmd_valid), .o_cmd_data(cmd_data), .i_cmd_ready(cmd_ready),
    .i_res_valid(res_valid), .i_res_data(res_data), .i_res_bus_error(res_bus_error_termination),
    .i_res_illegal(res_ill), .i_supervisor_bit(sup),
    .o_flush(flush), .o_fetch_addr(fetch_addr), .o_fetch_supervisor(fetch_sup),
    .o_odd_fetch_error(odd_err), .o_debug_enabled(dbg_en), .o_return_pointer(ret_ptr)
  );

  bdsp_host_model u_bdsp_host_model (.o_clk(host_clk), .o_data(host_dout), .i_data(pipe_pin));

  always #50 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Core side: takes received words and records exit events.
  always @(posedge clk) begin
    cycles++;
    if (odd_err) odd_seen = 1'b1;
    if (flush) begin
      n_flush++;
      f_addr = fetch_addr;
      f_halt = halted;
      f_sup = fetch_sup;
    end
    if (cmd_valid && cmd_ready) begin
      if (cq.size() == 0) `CHECK_EQ(1'b1, 1'b0)
      else `CHECK_EQ(cmd_data, cq.pop_front())
    end
    if (cycles > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  always @(negedge clk) cmd_ready <= !stall && (($random(seed) & 3) != 0);

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic [16:0] cw(input logic [5:0] op, input logic rw,
                                     input logic [2:0] rg);
    return {1'b0, op, 1'b0, rw, bdsp_pkg::SIZE_LONG, 2'b00, 1'b0, rg};
  endfunction

  // One serial word; bit 17 of the expected response marks it as not checked.
  task automatic xf(input logic [16:0] w);
    logic [16:0] r;
    n_flush = 0;
    cq.push_back(w[15:0]);
    u_bdsp_host_model.xfer(w, r);
    if (!exp_tx[17]) `CHECK_EQ(r, exp_tx[16:0])
    exp_tx = exp_q.size() ? exp_q.pop_front() : 18'h10000;
    cyc(5);
  endtask

  task automatic rdreg(input logic [2:0] rg, input logic [31:0] v);
    exp_q.push_back({2'b00, v[31:16]});
    exp_q.push_back({2'b00, v[15:0]});
    xf(cw(bdsp_pkg::OPC_READ_REG, 1'b1, rg));
    xf(cw(bdsp_pkg::OPC_NOP, 1'b0, 3'h0));
    xf(cw(bdsp_pkg::OPC_NOP, 1'b0, 3'h0));
  endtask

  // Kind 0 data, 1 bus error, 2 illegal, 3 no answer at all.
  task automatic res(input int k, input logic [15:0] d);
    res_valid = (k == 0);
    res_bus_error_termination = (k == 1);
    res_ill = (k == 2);
    res_data = d;
    cyc(1);
    res_valid = 1'b0;
    res_bus_error_termination = 1'b0;
    res_ill = 1'b0;
    if (k < 3) exp_tx = (k == 1) ? 18'h10001 : (k == 2) ? 18'h1FFFF : {2'b00, d};
  endtask

  task automatic exitw(input logic [31:0] a);
    cyc(12);
    `CHECK_EQ(n_flush, 1)
    `CHECK_EQ(f_addr, a)
    `CHECK_EQ(f_sup, sup)
    `CHECK_EQ(f_halt, 1'b0)
    `CHECK_EQ(odd_seen, a[0])
    odd_seen = 1'b0;
    exp_tx = 18'h20000;
  endtask

  task automatic enter(input logic op, input logic df);
    entry_op = op;
    dbl = df;
    cyc(1);
    entry_op = 1'b0;
    dbl = 1'b0;
    cyc(4);
    `CHECK_EQ(halted, op | df)
    exp_tx = 18'h20000;
  endtask

  initial begin
    cyc(4);
    srst = 1'b0;
    cyc(5);
    breakpoint_request_n_n = 1'b1;
    cyc(4);
    `CHECK_EQ(dbg_en, 1'b1)
    `CHECK_EQ(halted, 1'b1)
    rdreg(bdsp_pkg::SREG_SCRATCH, bdsp_pkg::SRC_BREAKPOINT);
    for (int k = 0; k < 5; k++) begin
      rnd16 = $random(seed);
      xf({1'b1, bdsp_pkg::OPC_NOP, rnd16[9:0]});
      res(k % 4, (k == 4) ? bdsp_pkg::RESP_ALL_ONES : rnd16);
    end
    xf(cw(bdsp_pkg::OPC_NOP, 1'b0, 3'h0));
    stall = 1'b1;
    cyc(2);
    xf(cw(bdsp_pkg::OPC_NOP, 1'b0, 3'h1));
    xf(cw(bdsp_pkg::OPC_NOP, 1'b0, 3'h2));
    cyc(20);
    `CHECK_EQ(cmd_valid, 1'b1)
    stall = 1'b0;
    rp = $random(seed);
    rp[0] = 1'b1;
    sup = 1'b0;
    xf(cw(bdsp_pkg::OPC_WRITE_REG, 1'b0, bdsp_pkg::SREG_RETURN));
    xf({1'b0, rp[31:16]});
    xf({1'b0, rp[15:0]});
    cyc(4);
    `CHECK_EQ(ret_ptr, rp)
    exp_tx = 18'h20000;
    xf(cw(bdsp_pkg::OPC_RESUME, 1'b0, 3'h0));
    exitw(rp);
    for (int i = 0; i < 8; i++) begin
      pipe_core = $random(seed);
      cyc(2);
      `CHECK_EQ(pipe_pin, pipe_core)
    end
    bus_addr = $random(seed);
    bus_cyc = 1'b1;
    bus_flt = 1'b1;
    cyc(1);
    bus_cyc = 1'b0;
    bus_flt = 1'b0;
    last_addr = $random(seed);
    last_addr[0] = 1'b0;
    enter(1'b1, 1'b0);
    rdreg(bdsp_pkg::SREG_SCRATCH, {bdsp_pkg::SRC_OPCODE_HI, bdsp_pkg::SRC_OPCODE_LO});
    rdreg(bdsp_pkg::SREG_CURRENT, last_addr);
    rdreg(bdsp_pkg::SREG_FAULT, bus_addr);
    sup = 1'b1;
    xf(cw(bdsp_pkg::OPC_CALL, 1'b0, 3'h0));
    exitw(last_addr);
    special_status_word = $random(seed);
    from_rst = 1'b1;
    enter(1'b0, 1'b1);
    from_rst = 1'b0;
    rdreg(bdsp_pkg::SREG_SCRATCH, {special_status_word, bdsp_pkg::RESP_ALL_ONES});
    rdreg(bdsp_pkg::SREG_CURRENT, bdsp_pkg::PTR_RESET_FAULT);
    xf(cw(bdsp_pkg::OPC_RESUME, 1'b0, 3'h0));
    exitw(last_addr);
    srst = 1'b1;
    cyc(4);
    srst = 1'b0;
    cyc(4);
    `CHECK_EQ(dbg_en, 1'b0)
    enter(1'b0, 1'b0);
    entry_op = 1'b1;
    breakpoint_request_n_n = 1'b0;
    cyc(1);
    entry_op = 1'b0;
    cyc(4);
    breakpoint_request_n_n = 1'b1;
    cyc(4);
    `CHECK_EQ(halted, 1'b0)
    cyc(20);
    `CHECK_EQ(cq.size(), 0)
    tally_and_finish();
  end
endmodule // tb_bdsp_port
